// ===== design/equalizer_pkg.sv
// shared constants, types and states of the complex fractionally spaced equalizer
package equalizer_pkg;
   // filter length; the delay line address wraps naturally, so it is a power of two
   localparam int TAP_COUNT = 16;
   localparam int ADDR_W = 4;
   localparam int SAMPLE_W = 16;
   localparam int PROD_W = 32;
   localparam int ACC_W = 40;
   // products of two 1.15 values carry thirty fraction bits
   localparam int PROD_FRAC = 30;
   localparam int OUT_SHIFT = 15;
   // step size is a power of two: beta = 2^-STEP_SHIFT
   localparam int STEP_SHIFT = 6;
   localparam logic [ADDR_W-1:0] LAST_TAP = 4'h0F;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 4'h1;
   localparam logic [ACC_W-1:0] ROUND_HALF = 40'h00_0000_4000;
   localparam logic [SAMPLE_W-1:0] SAT_POS = 16'h7FFF;
   localparam logic [SAMPLE_W-1:0] SAT_NEG = 16'h8000;
   localparam logic [SAMPLE_W-1:0] WORD_ZERO = 16'h0000;
   localparam logic [ACC_W-1:0] ACC_ZERO = 40'h00_0000_0000;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] re;
      logic signed [SAMPLE_W-1:0] im;
   } cplx_type;

   localparam cplx_type CPLX_ZERO = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FILTER = 3'b001,
      ST_OUTPUT = 3'b010,
      ST_WAIT_REF = 3'b011,
      ST_UPDATE = 3'b100
   } eq_state_type;
endpackage

// ===== design/tap_memory.sv
// complex entry store with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module tap_memory
   import equalizer_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic wr_en, // write strobe
   input wire logic [ADDR_W-1:0] wr_addr, // write index
   input wire cplx_type wr_data, // write value
   input wire logic [ADDR_W-1:0] rd_addr, // read index
   output cplx_type rd_data // read value, one cycle later
);
   cplx_type entry [TAP_COUNT];

   // cleared entry by entry so the whole line reads zero after reset
   genvar g;
   generate
      for (g = 0; g < TAP_COUNT; g++) begin : g_entry
         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               entry[g] <= CPLX_ZERO;
            end else if (wr_en && (wr_addr == ADDR_W'(g))) begin
               entry[g] <= wr_data;
            end
         end
      end
   endgenerate

   // a write and a read of the same index return the old value
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= CPLX_ZERO;
      end else begin
         rd_data <= entry[rd_addr];
      end
   end
endmodule // tap_memory
`default_nettype wire

// ===== design/sat_round.sv
// rounds a wide 30-fraction-bit value to 1.15 and saturates on overflow
`timescale 1ns/1ps
`default_nettype none
module sat_round
   import equalizer_pkg::*;
(
   input wire logic signed [ACC_W-1:0] value, // wide value, 30 fraction bits
   output logic signed [SAMPLE_W-1:0] result // rounded, saturated 1.15
);
   logic signed [ACC_W-1:0] rounded;
   logic fits;

   always_comb begin
      rounded = value + ROUND_HALF;
      // every bit above the 1.15 sign must copy it, or the value left full scale
      fits = (rounded[ACC_W-1:PROD_FRAC] == {(ACC_W-PROD_FRAC){rounded[PROD_FRAC]}});
      if (fits) begin
         result = rounded[PROD_FRAC:OUT_SHIFT];
      end else if (rounded[ACC_W-1]) begin
         result = SAT_NEG;
      end else begin
         result = SAT_POS;
      end
   end
endmodule // sat_round
`default_nettype wire

// ===== design/complex_fse_equalizer.sv
// complex fractionally spaced LMS equalizer: delay line, filter, error and tap update
`timescale 1ns/1ps
`default_nettype none
module complex_fse_equalizer
   import equalizer_pkg::*;
(
   input wire logic clock, // 40 MHz system clock
   input wire logic rst_b, // async reset, active low
   input wire logic sample_valid, // front end sample strobe
   input wire cplx_type sample, // complex 1.15 input sample
   output logic sample_ready, // high while a sample can be taken
   output logic out_valid, // one-cycle output strobe
   output cplx_type out_data, // complex 1.15 equalized output
   input wire logic ref_valid, // reference symbol strobe
   input wire cplx_type ref_symbol, // ideal or decided symbol, 1.15
   output logic err_valid, // one-cycle error strobe
   output cplx_type err_data, // output minus reference, 1.15
   output logic phase // input phase flag
);
   eq_state_type state;
   logic [ADDR_W-1:0] wr_ptr;
   logic [ADDR_W-1:0] issue_k;
   logic [ADDR_W-1:0] rd_k;
   logic issue_on;
   logic rd_v;
   logic accept;
   logic start;
   logic ref_take;
   logic coef_we;
   logic [ADDR_W-1:0] line_addr;
   cplx_type line_q;
   cplx_type coef_q;
   cplx_type coef_new;
   cplx_type beta_err;
   cplx_type next_err;
   logic signed [ACC_W-1:0] acc_re;
   logic signed [ACC_W-1:0] acc_im;
   logic signed [ACC_W-1:0] upd_re;
   logic signed [ACC_W-1:0] upd_im;
   logic signed [SAMPLE_W-1:0] y_re;
   logic signed [SAMPLE_W-1:0] y_im;
   logic signed [PROD_W-1:0] p_rr;
   logic signed [PROD_W-1:0] p_ii;
   logic signed [PROD_W-1:0] p_ri;
   logic signed [PROD_W-1:0] p_ir;
   logic signed [PROD_W-1:0] q_rr;
   logic signed [PROD_W-1:0] q_ii;
   logic signed [PROD_W-1:0] q_ri;
   logic signed [PROD_W-1:0] q_ir;

   function automatic logic signed [SAMPLE_W-1:0] sat_diff(input logic signed [SAMPLE_W:0] d);
      if (d[SAMPLE_W] != d[SAMPLE_W-1]) begin
         sat_diff = d[SAMPLE_W] ? SAT_NEG : SAT_POS;
      end else begin
         sat_diff = d[SAMPLE_W-1:0];
      end
   endfunction

   assign accept = sample_valid && sample_ready;
   assign start = accept && phase;
   assign ref_take = (state == ST_WAIT_REF) && ref_valid;
   // oldest entry is the one the next sample will overwrite
   assign line_addr = wr_ptr + issue_k;
   assign coef_we = rd_v && (state == ST_UPDATE);

   tap_memory delay_line (
      .clock(clock),
      .rst_b(rst_b),
      .wr_en(accept),
      .wr_addr(wr_ptr),
      .wr_data(sample),
      .rd_addr(line_addr),
      .rd_data(line_q)
   );

   tap_memory coef_table (
      .clock(clock),
      .rst_b(rst_b),
      .wr_en(coef_we),
      .wr_addr(rd_k),
      .wr_data(coef_new),
      .rd_addr(issue_k),
      .rd_data(coef_q)
   );

   // new sample overwrites the oldest; flag decides whether to filter
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= ADDR_ZERO;
         phase <= 1'b0;
      end else if (accept) begin
         wr_ptr <= wr_ptr + ADDR_ONE;
         phase <= ~phase;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         sample_ready <= 1'b1;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start) begin
                  state <= ST_FILTER;
                  sample_ready <= 1'b0;
               end
            end
            ST_FILTER: begin
               if (rd_v && (rd_k == LAST_TAP)) begin
                  state <= ST_OUTPUT;
               end
            end
            ST_OUTPUT: begin
               state <= ST_WAIT_REF;
            end
            ST_WAIT_REF: begin
               if (ref_valid) begin
                  state <= ST_UPDATE;
               end
            end
            ST_UPDATE: begin
               if (rd_v && (rd_k == LAST_TAP)) begin
                  state <= ST_IDLE;
                  sample_ready <= 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
               sample_ready <= 1'b1;
            end
         endcase
      end
   end

   // walks the taps once per pass, first coefficient paired with oldest sample
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         issue_on <= 1'b0;
         issue_k <= ADDR_ZERO;
      end else if (start || ref_take) begin
         issue_on <= 1'b1;
         issue_k <= ADDR_ZERO;
      end else if (issue_on) begin
         issue_k <= issue_k + ADDR_ONE;
         issue_on <= (issue_k != LAST_TAP);
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rd_v <= 1'b0;
         rd_k <= ADDR_ZERO;
      end else begin
         rd_v <= issue_on;
         rd_k <= issue_k;
      end
   end

   always_comb begin
      p_rr = line_q.re * coef_q.re;
      p_ii = line_q.im * coef_q.im;
      p_ri = line_q.re * coef_q.im;
      p_ir = line_q.im * coef_q.re;
   end

   // wide accumulators keep every partial sum; only the final value is clipped
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         acc_re <= ACC_ZERO;
         acc_im <= ACC_ZERO;
      end else if (start) begin
         acc_re <= ACC_ZERO;
         acc_im <= ACC_ZERO;
      end else if (rd_v && (state == ST_FILTER)) begin
         acc_re <= acc_re + ACC_W'(p_rr) - ACC_W'(p_ii);
         acc_im <= acc_im + ACC_W'(p_ri) + ACC_W'(p_ir);
      end
   end

   sat_round round_re (
      .value(acc_re),
      .result(y_re)
   );

   sat_round round_im (
      .value(acc_im),
      .result(y_im)
   );

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         out_valid <= 1'b0;
         out_data <= CPLX_ZERO;
      end else begin
         out_valid <= (state == ST_OUTPUT);
         if (state == ST_OUTPUT) begin
            out_data <= {y_re, y_im};
         end
      end
   end

   always_comb begin
      next_err.re = sat_diff({out_data.re[SAMPLE_W-1], out_data.re}
                           - {ref_symbol.re[SAMPLE_W-1], ref_symbol.re});
      next_err.im = sat_diff({out_data.im[SAMPLE_W-1], out_data.im}
                           - {ref_symbol.im[SAMPLE_W-1], ref_symbol.im});
   end

   // step size as a shift keeps the update multiplier free; beta is coarse as a result
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         err_valid <= 1'b0;
         err_data <= CPLX_ZERO;
         beta_err <= CPLX_ZERO;
      end else begin
         err_valid <= ref_take;
         if (ref_take) begin
            err_data <= next_err;
            beta_err.re <= next_err.re >>> STEP_SHIFT;
            beta_err.im <= next_err.im >>> STEP_SHIFT;
         end
      end
   end

   // e times conj(x): real Er*Xr + Ei*Xi, imaginary Ei*Xr - Er*Xi
   always_comb begin
      q_rr = beta_err.re * line_q.re;
      q_ii = beta_err.im * line_q.im;
      q_ir = beta_err.im * line_q.re;
      q_ri = beta_err.re * line_q.im;
      upd_re = (ACC_W'(coef_q.re) <<< OUT_SHIFT) - ACC_W'(q_rr) - ACC_W'(q_ii);
      upd_im = (ACC_W'(coef_q.im) <<< OUT_SHIFT) - ACC_W'(q_ir) + ACC_W'(q_ri);
   end

   sat_round round_upd_re (
      .value(upd_re),
      .result(coef_new.re)
   );

   sat_round round_upd_im (
      .value(upd_im),
      .result(coef_new.im)
   );

   // helper for checks: cycles spent in the filter pass
   logic [7:0] filter_cycles;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         filter_cycles <= 8'h00;
      end else if (state == ST_FILTER) begin
         filter_cycles <= filter_cycles + 8'h01;
      end else begin
         filter_cycles <= 8'h00;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence s_second_sample;
      sample_valid && sample_ready && phase;
   endsequence

   sequence s_pass_begins;
      (state == ST_FILTER) && issue_on && (issue_k == ADDR_ZERO);
   endsequence

   property p_phase_toggle;
      (sample_valid && sample_ready) |=> (phase != $past(phase));
   endproperty
   a_phase_toggle: assert property (p_phase_toggle) else $error("phase flag did not toggle");

   property p_start_second;
      s_second_sample |=> s_pass_begins;
   endproperty
   a_start_second: assert property (p_start_second) else $error("pass did not start");

   property p_first_no_start;
      (sample_valid && sample_ready && !phase && state == ST_IDLE) |=> (state == ST_IDLE);
   endproperty
   a_first_no_start: assert property (p_first_no_start) else $error("filtered on first sample");

   property p_filter_length;
      (state == ST_OUTPUT) |-> (filter_cycles == 8'h11) ##1 (filter_cycles == 8'h00);
   endproperty
   a_filter_length: assert property (p_filter_length) else $error("filter pass length wrong");

   property p_out_strobe;
      (state == ST_OUTPUT) |=> out_valid ##1 !out_valid;
   endproperty
   a_out_strobe: assert property (p_out_strobe) else $error("output strobe wrong");

   property p_ptr_advance;
      (sample_valid && sample_ready) |=> (wr_ptr == $past(wr_ptr) + ADDR_ONE);
   endproperty
   a_ptr_advance: assert property (p_ptr_advance) else $error("delay line pointer stuck");

   property p_update_follows;
      ((state == ST_WAIT_REF) && ref_valid) |=> (state == ST_UPDATE) && err_valid ##16 coef_we;
   endproperty
   a_update_follows: assert property (p_update_follows) else $error("update pass wrong");

   property p_coef_only_update;
      coef_we |-> (state == ST_UPDATE) && !sample_ready;
   endproperty
   a_coef_only_update: assert property (p_coef_only_update) else $error("tap write outside update");

   property p_sat_positive;
      ((state == ST_OUTPUT) && !acc_re[ACC_W-1] && (acc_re[ACC_W-2:PROD_FRAC] != '0))
         |=> (out_data.re == SAT_POS);
   endproperty
   a_sat_positive: assert property (p_sat_positive) else $error("no positive saturation");
endmodule // complex_fse_equalizer
`default_nettype wire

// ===== verif/front_end_model.sv
// receiver front end model that hands complex samples to the equalizer
`timescale 1ns/1ps
`default_nettype none
module front_end_model
   import equalizer_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic sample_ready, // device can take a sample
   output logic sample_valid, // sample strobe
   output cplx_type sample // complex 1.15 sample
);
   initial begin
      sample_valid = 1'b0;
      sample = 32'h5A5A_A5A5;
   end

   // call just after a rising edge; hold keeps the strobe up for a following sample
   task automatic push(input cplx_type x, input bit hold);
      sample_valid <= 1'b1;
      sample <= x;
      @(negedge clock);
      while (sample_ready !== 1'b1) @(negedge clock);
      @(posedge clock);
      if (!hold) begin
         sample_valid <= 1'b0;
         // a released bus must not look like the last sample
         sample <= ~x;
      end
   endtask

   // one strobe regardless of ready, to provoke a refusal
   task automatic stray(input cplx_type x);
      sample_valid <= 1'b1;
      sample <= x;
      @(posedge clock);
      sample_valid <= 1'b0;
      sample <= ~x;
   endtask
endmodule // front_end_model
`default_nettype wire

// ===== verif/testbench.sv
// self-checking testbench of the complex fractionally spaced equalizer
`timescale 1ns/1ps
`default_nettype none
module testbench
   import equalizer_pkg::*;
;
   logic clock, rst_b, sample_valid, sample_ready, out_valid, ref_valid, err_valid, phase;
   cplx_type sample, out_data, ref_symbol, err_data;
   int n_fail, compares, wp, yr, yi;
   int xr[16], xi[16], cr[16], ci[16];

   complex_fse_equalizer dut (.clock(clock), .rst_b(rst_b), .sample_valid(sample_valid),
      .sample(sample), .sample_ready(sample_ready), .out_valid(out_valid),
      .out_data(out_data), .ref_valid(ref_valid), .ref_symbol(ref_symbol),
      .err_valid(err_valid), .err_data(err_data), .phase(phase));
   front_end_model fe (.clock(clock), .sample_ready(sample_ready),
      .sample_valid(sample_valid), .sample(sample));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   initial begin
      repeat (8000) @(posedge clock);
      n_fail = n_fail + 1;
      $display("MISMATCH %0t watchdog expired", $time);
      test_done();
   end

   task automatic test_done();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s got %b exp %b", $time, msg, got, exp);
      end
   endtask

   task automatic chk_cplx(input cplx_type got, input cplx_type exp, input string msg);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   function automatic int clamp(input longint v);
      return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : int'(v));
   endfunction

   // round a 30-fraction-bit value to 1.15, saturating on overflow
   function automatic int sr(input longint v);
      return clamp((v + 16384) >>> 15);
   endfunction

   function automatic cplx_type pk(input int r, input int i);
      return {16'(r), 16'(i)};
   endfunction

   function automatic cplx_type smp(input int i);
      return {16'(i * 16'h1D3B), 16'(16'h0101 - i * 16'h2F17)};
   endfunction

   task automatic m_reset();
      wp = 0;
      for (int n = 0; n < 16; n++) begin
         xr[n] = 0;
         xi[n] = 0;
         cr[n] = 0;
         ci[n] = 0;
      end
   endtask

   task automatic m_take(input cplx_type x);
      xr[wp] = x.re;
      xi[wp] = x.im;
      wp = (wp + 1) % 16;
   endtask

   // after a pair, wp points at the oldest entry, which meets tap 0
   task automatic m_filter();
      longint ar, ai;
      int k;
      ar = 0;
      ai = 0;
      for (int n = 0; n < 16; n++) begin
         k = (wp + n) % 16;
         ar += longint'(xr[k]) * cr[n] - longint'(xi[k]) * ci[n];
         ai += longint'(xr[k]) * ci[n] + longint'(xi[k]) * cr[n];
      end
      yr = sr(ar);
      yi = sr(ai);
   endtask

   task automatic m_update(input int er, input int ei);
      int k, br, bi;
      br = er >>> 6;
      bi = ei >>> 6;
      for (int n = 0; n < 16; n++) begin
         k = (wp + n) % 16;
         cr[n] = sr((longint'(cr[n]) <<< 15) - longint'(br) * xr[k] - longint'(bi) * xi[k]);
         ci[n] = sr((longint'(ci[n]) <<< 15) - longint'(bi) * xr[k] + longint'(br) * xi[k]);
      end
   endtask

   task automatic chk_idle();
      @(negedge clock);
      chk_bit(sample_ready, 1'b1, "ready at reset");
      chk_bit(out_valid, 1'b0, "out strobe at reset");
      chk_bit(err_valid, 1'b0, "err strobe at reset");
      chk_bit(phase, 1'b0, "phase at reset");
      chk_cplx(out_data, CPLX_ZERO, "output at reset");
      chk_cplx(err_data, CPLX_ZERO, "error at reset");
   endtask

   // rest of a symbol once its pair has been taken
   task automatic sym_end(input cplx_type r);
      int k, er, ei;
      m_filter();
      @(negedge clock);
      chk_bit(phase, 1'b0, "phase after pair");
      chk_bit(sample_ready, 1'b0, "ready during pass");
      k = 0;
      while (out_valid !== 1'b1 && k < 40) begin
         chk_bit(err_valid, 1'b0, "early error strobe");
         @(negedge clock);
         k++;
      end
      chk_bit(out_valid, 1'b1, "output strobe");
      chk_cplx(out_data, pk(yr, yi), "output");
      @(posedge clock);
      ref_valid <= 1'b1;
      ref_symbol <= r;
      @(posedge clock);
      ref_valid <= 1'b0;
      ref_symbol <= ~r;
      er = clamp(yr - r.re);
      ei = clamp(yi - r.im);
      @(negedge clock);
      chk_bit(out_valid, 1'b0, "output strobe width");
      chk_bit(err_valid, 1'b1, "error strobe");
      chk_cplx(err_data, pk(er, ei), "error");
      m_update(er, ei);
      k = 0;
      while (sample_ready !== 1'b1 && k < 40) begin
         @(negedge clock);
         k++;
      end
      chk_bit(sample_ready, 1'b1, "ready after update");
      @(posedge clock);
   endtask

   task automatic do_symbol(input cplx_type a, input cplx_type b, input cplx_type r);
      fe.push(a, 1'b1);
      m_take(a);
      fe.push(b, 1'b0);
      m_take(b);
      sym_end(r);
   endtask

   task automatic t_phase();
      fe.push(smp(1), 1'b0);
      m_take(smp(1));
      repeat (20) begin
         @(negedge clock);
         chk_bit(out_valid, 1'b0, "output after one sample");
      end
      chk_bit(phase, 1'b1, "phase after one sample");
      chk_bit(sample_ready, 1'b1, "ready after one sample");
      @(posedge clock);
      fe.push(smp(2), 1'b0);
      m_take(smp(2));
      sym_end(smp(40));
   endtask

   task automatic t_train();
      for (int i = 3; i < 27; i += 2) begin
         do_symbol(smp(i), smp(i + 1), smp(i + 60));
      end
   endtask

   task automatic t_err_sat();
      do_symbol(CPLX_ZERO, smp(5), {SAT_NEG, SAT_POS});
   endtask

   // stray sample and reference during a pass must leave no trace
   task automatic t_refuse();
      fe.push(smp(30), 1'b1);
      m_take(smp(30));
      fe.push(smp(31), 1'b0);
      m_take(smp(31));
      fork
         sym_end(smp(70));
         begin
            repeat (3) @(posedge clock);
            ref_valid <= 1'b1;
            fe.stray(smp(99));
            ref_valid <= 1'b0;
         end
      join
      do_symbol(smp(32), smp(33), smp(71));
   endtask

   task automatic t_reset_mid();
      rst_b <= 1'b0;
      chk_idle();
      @(posedge clock);
      rst_b <= 1'b1;
      m_reset();
      chk_idle();
      @(posedge clock);
      do_symbol(smp(7), smp(8), smp(9));
   endtask

   // long training at half scale leaves tap sum near two, so full-scale input overflows
   task automatic t_out_sat();
      cplx_type half, full;
      half = {16'h4000, WORD_ZERO};
      full = {SAT_POS, WORD_ZERO};
      repeat (48) do_symbol(half, half, full);
      repeat (4) do_symbol(full, full, full);
   endtask

   initial begin
      n_fail = 0;
      compares = 0;
      rst_b = 1'b0;
      ref_valid = 1'b0;
      ref_symbol = CPLX_ZERO;
      m_reset();
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      chk_idle();
      @(posedge clock);
      t_phase();
      t_train();
      t_err_sat();
      t_refuse();
      t_reset_mid();
      t_out_sat();
      test_done();
   end
endmodule // testbench
`default_nettype wire
